// ### hw/tcc_timer.v

`default_nettype none

module tcc_timer (
   // Clock and reset.
   input  wire        sys_clk,
   input  wire        rst,
   // APB slave.
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   // Timer tick from the clock-select logic.
   input  wire        timer_tick,
   // Outputs towards prescaler, interrupt and waveform logic.
   output wire [2:0]  clock_source_sel,
   output wire        count_overflow_flag,
   output wire [15:0] timer_count_value,
   output wire [15:0] compare_a_value,
   output wire [15:0] compare_b_value,
   output wire [15:0] capture_value,
   output wire        top_reached,
   output wire        bottom_reached,
   output wire        count_down
);

   `include "tcc_timer_defs.vh"

   reg  [1:0]  ctrl_a_wgm_reg;   // Low half of the mode field.
   reg  [1:0]  ctrl_b_wgm_reg;   // High half of the mode field.
   reg  [2:0]  cs_reg;           // Clock-source field.
   reg  [7:0]  latch_reg;        // Shared high-byte latch.
   reg  [15:0] cmpa_buf_reg;     // Compare A as written by software.
   reg  [15:0] cmpb_buf_reg;     // Compare B as written by software.
   reg  [15:0] cmpa_act_reg;     // Compare A in use by the counter.
   reg  [15:0] cmpb_act_reg;     // Compare B in use by the counter.
   reg  [15:0] capt_reg;         // Capture register.
   reg         ovf_reg;          // Overflow flag.
   reg  [31:0] rdata_next;       // Read data for the current setup cycle.
   reg         addr_ok;          // Address decodes to a register.
   reg  [15:0] top_value;        // Selected upper limit.
   reg         pwm_mode;         // Compare registers double buffered.
   reg         dual_slope;       // Up-down counting.
   reg         pfc_mode;         // Buffers update at bottom instead of top.
   reg         capt_is_top;      // Capture register sets the limit.
   reg         ovf_event;        // Overflow point reached on this tick.
   wire [3:0]  wave_gen_mode;    // Full four-bit mode field.
   wire        access;           // APB access phase.
   wire        wr;               // Write taking effect this edge.
   wire        rd;               // Read setup edge, where the low byte is sampled.
   wire        tick_en;          // Tick that is allowed to move the counter.
   wire        count_load;       // Software load of the counter.
   wire [15:0] count_reg;        // Counter value.
   wire        at_top;           // Counter equals its limit.
   wire        at_bottom;        // Counter equals zero.
   wire        buf_update;       // Copy buffers into active compare values.

   // Mode field split across both control words.
   assign wave_gen_mode = {ctrl_b_wgm_reg, ctrl_a_wgm_reg};

   // Zero wait states; the data was captured in the setup cycle.
   assign pready  = 1'b1;
   assign pslverr = access & ~addr_ok;
   assign access  = psel & penable;
   assign wr      = access & pwrite & addr_ok;
   assign rd      = psel & ~penable & ~pwrite & addr_ok;

   // A stopped clock source blocks every tick.
   assign tick_en    = timer_tick & (cs_reg != `TCC_CS_STOPPED);
   assign count_load = wr & (paddr == `TCC_OFS_COUNT_LO);

   assign clock_source_sel    = cs_reg;
   assign count_overflow_flag = ovf_reg;
   assign timer_count_value   = count_reg;
   assign compare_a_value     = cmpa_act_reg;
   assign compare_b_value     = cmpb_act_reg;
   assign capture_value       = capt_reg;
   assign top_reached         = at_top;
   assign bottom_reached      = at_bottom;

   // Mode decode: limit source, slope and buffering for each mode.
   always @* begin
      pwm_mode    = 1'b1;
      dual_slope  = 1'b0;
      pfc_mode    = 1'b0;
      capt_is_top = 1'b0;
      top_value   = `TCC_MAX;
      case (wave_gen_mode)
         4'h0: begin
            pwm_mode = 1'b0; // Normal mode wraps at the maximum.
         end
         4'h1: begin
            dual_slope = 1'b1;
            top_value  = `TCC_TOP_8BIT;
         end
         4'h2: begin
            dual_slope = 1'b1;
            top_value  = `TCC_TOP_9BIT;
         end
         4'h3: begin
            dual_slope = 1'b1;
            top_value  = `TCC_TOP_10BIT;
         end
         4'h4: begin
            pwm_mode  = 1'b0;
            top_value = cmpa_act_reg;
         end
         4'h5: top_value = `TCC_TOP_8BIT;
         4'h6: top_value = `TCC_TOP_9BIT;
         4'h7: top_value = `TCC_TOP_10BIT;
         4'h8: begin
            dual_slope  = 1'b1;
            pfc_mode    = 1'b1;
            capt_is_top = 1'b1;
            top_value   = capt_reg;
         end
         4'h9: begin
            dual_slope = 1'b1;
            pfc_mode   = 1'b1;
            top_value  = cmpa_act_reg;
         end
         4'hA: begin
            dual_slope  = 1'b1;
            capt_is_top = 1'b1;
            top_value   = capt_reg;
         end
         4'hB: begin
            dual_slope = 1'b1;
            top_value  = cmpa_act_reg;
         end
         4'hC: begin
            pwm_mode    = 1'b0;
            capt_is_top = 1'b1;
            top_value   = capt_reg;
         end
         4'hE: begin
            capt_is_top = 1'b1;
            top_value   = capt_reg;
         end
         4'hF: top_value = cmpa_act_reg;
         default: begin
            pwm_mode = 1'b0; // Reserved code behaves as normal mode.
         end
      endcase
   end

   // Overflow point: maximum in non-PWM modes, limit in single slope, zero in dual slope.
   always @* begin
      if (!pwm_mode) begin
         ovf_event = tick_en & (count_reg == `TCC_MAX);
      end else if (dual_slope) begin
         ovf_event = tick_en & at_bottom & count_down;
      end else begin
         ovf_event = tick_en & at_top;
      end
   end

   // In PWM modes the new compare values wait for the limit or zero so no pulse is cut short.
   assign buf_update = tick_en & (pfc_mode ? at_bottom : at_top);

   // Address decode and read mux, evaluated in the setup cycle.
   always @* begin
      addr_ok    = 1'b1;
      rdata_next = 32'h00000000;
      case (paddr)
         `TCC_OFS_CTRL_A:   rdata_next[1:0] = ctrl_a_wgm_reg;
         `TCC_OFS_CTRL_B:   rdata_next[4:0] = {ctrl_b_wgm_reg, cs_reg};
         `TCC_OFS_COUNT_LO: rdata_next[7:0] = count_reg[7:0];
         `TCC_OFS_COUNT_HI: rdata_next[7:0] = latch_reg;
         `TCC_OFS_CMPA_LO:  rdata_next[7:0] = cmpa_buf_reg[7:0];
         `TCC_OFS_CMPA_HI:  rdata_next[7:0] = cmpa_buf_reg[15:8];
         `TCC_OFS_CMPB_LO:  rdata_next[7:0] = cmpb_buf_reg[7:0];
         `TCC_OFS_CMPB_HI:  rdata_next[7:0] = cmpb_buf_reg[15:8];
         `TCC_OFS_CAPT_LO:  rdata_next[7:0] = capt_reg[7:0];
         `TCC_OFS_CAPT_HI:  rdata_next[7:0] = latch_reg;
         `TCC_OFS_FLAGS:    rdata_next[`TCC_FLAGS_OVF] = ovf_reg;
         default:           addr_ok = 1'b0;
      endcase
   end

   // Read data register, loaded in the setup cycle and held through the access.
   always @(posedge sys_clk) begin
      if (rst) begin
         prdata <= 32'h00000000;
      end else if (psel & ~penable & ~pwrite) begin
         prdata <= rdata_next;
      end
   end

   // Control words; the mode and clock source steer the counter directly.
   always @(posedge sys_clk) begin
      if (rst) begin
         ctrl_a_wgm_reg <= 2'h0;
         ctrl_b_wgm_reg <= 2'h0;
         cs_reg         <= `TCC_RST_CS;
      end else if (wr && paddr == `TCC_OFS_CTRL_A) begin
         ctrl_a_wgm_reg <= pwdata[`TCC_CTRLA_WGM_LO+1:`TCC_CTRLA_WGM_LO];
      end else if (wr && paddr == `TCC_OFS_CTRL_B) begin
         ctrl_b_wgm_reg <= pwdata[`TCC_CTRLB_WGM_LO+1:`TCC_CTRLB_WGM_LO];
         cs_reg         <= pwdata[`TCC_CTRLB_CS_LO+2:`TCC_CTRLB_CS_LO];
      end
   end

   // Shared latch: high writes, or counter or capture low-read setup edge so both bytes share one value.
   always @(posedge sys_clk) begin
      if (rst) begin
         latch_reg <= `TCC_RST_BYTE;
      end else if (wr && (paddr == `TCC_OFS_COUNT_HI || paddr == `TCC_OFS_CMPA_HI ||
                          paddr == `TCC_OFS_CMPB_HI || paddr == `TCC_OFS_CAPT_HI)) begin
         latch_reg <= pwdata[7:0];
      end else if (rd && paddr == `TCC_OFS_COUNT_LO) begin
         latch_reg <= count_reg[15:8];
      end else if (rd && paddr == `TCC_OFS_CAPT_LO) begin
         latch_reg <= capt_reg[15:8];
      end
      // Low writes leave the latch alone, so one high byte serves several registers.
   end

   // Compare buffers take a whole word on the low-byte write.
   always @(posedge sys_clk) begin
      if (rst) begin
         cmpa_buf_reg <= `TCC_RST_WORD;
         cmpb_buf_reg <= `TCC_RST_WORD;
      end else begin
         if (wr && paddr == `TCC_OFS_CMPA_LO) begin
            cmpa_buf_reg <= {latch_reg, pwdata[7:0]};
         end
         if (wr && paddr == `TCC_OFS_CMPB_LO) begin
            cmpb_buf_reg <= {latch_reg, pwdata[7:0]};
         end
      end
   end

   // Active compare values follow the buffers at once outside PWM modes.
   always @(posedge sys_clk) begin
      if (rst) begin
         cmpa_act_reg <= `TCC_RST_WORD;
         cmpb_act_reg <= `TCC_RST_WORD;
      end else if (!pwm_mode || buf_update) begin
         cmpa_act_reg <= cmpa_buf_reg;
         cmpb_act_reg <= cmpb_buf_reg;
      end
   end

   // Capture register is writable only while it sets the limit.
   always @(posedge sys_clk) begin
      if (rst) begin
         capt_reg <= `TCC_RST_WORD;
      end else if (wr && paddr == `TCC_OFS_CAPT_LO && capt_is_top) begin
         capt_reg <= {latch_reg, pwdata[7:0]};
      end
   end

   // Overflow flag: writing one clears it, but a same-cycle overflow wins.
   always @(posedge sys_clk) begin
      if (rst) begin
         ovf_reg <= 1'b0;
      end else if (ovf_event) begin
         ovf_reg <= 1'b1;
      end else if (wr && paddr == `TCC_OFS_FLAGS && pwdata[`TCC_FLAGS_OVF]) begin
         ovf_reg <= 1'b0;
      end
   end

   // Counter unit; the load path carries the latched high byte.
   tcc_counter u_counter (
      .sys_clk    (sys_clk),
      .rst        (rst),
      .tick       (tick_en),
      .load       (count_load),
      .load_value ({latch_reg, pwdata[7:0]}),
      .top_value  (top_value),
      .dual_slope (dual_slope),
      .count_reg  (count_reg),
      .down_reg   (count_down),
      .at_top     (at_top),
      .at_bottom  (at_bottom)
   );

endmodule // tcc_timer

`default_nettype wire

// ### hw/tcc_timer_defs.vh
`ifndef TCC_TIMER_DEFS_VH
`define TCC_TIMER_DEFS_VH

// Byte addresses of the register words on the APB bus.
`define TCC_OFS_CTRL_A      8'h00
`define TCC_OFS_CTRL_B      8'h04
`define TCC_OFS_COUNT_LO    8'h08
`define TCC_OFS_COUNT_HI    8'h0C
`define TCC_OFS_CMPA_LO     8'h10
`define TCC_OFS_CMPA_HI     8'h14
`define TCC_OFS_CMPB_LO     8'h18
`define TCC_OFS_CMPB_HI     8'h1C
`define TCC_OFS_CAPT_LO     8'h20
`define TCC_OFS_CAPT_HI     8'h24
`define TCC_OFS_FLAGS       8'h28

// Field positions inside the control and flag words.
`define TCC_CTRLA_WGM_LO    0
`define TCC_CTRLB_CS_LO     0
`define TCC_CTRLB_WGM_LO    3
`define TCC_FLAGS_OVF       0

// Reset values.
`define TCC_RST_BYTE        8'h00
`define TCC_RST_WORD        16'h0000
`define TCC_RST_MODE        4'h0
`define TCC_RST_CS          3'h0

// Counter limits.
`define TCC_BOTTOM          16'h0000
`define TCC_MAX             16'hFFFF
`define TCC_TOP_8BIT        16'h00FF
`define TCC_TOP_9BIT        16'h01FF
`define TCC_TOP_10BIT       16'h03FF

// Clock-source field value that stops the counter.
`define TCC_CS_STOPPED      3'h0

`endif

// ### hw/tcc_counter.v
`default_nettype none

// Sixteen-bit bidirectional counter unit with load, count, direction and clear.
module tcc_counter (
   // Clock and reset.
   input  wire        sys_clk,
   input  wire        rst,
   // Control from the register side.
   input  wire        tick,
   input  wire        load,
   input  wire [15:0] load_value,
   input  wire [15:0] top_value,
   input  wire        dual_slope,
   // Counter state.
   output reg  [15:0] count_reg,
   output reg         down_reg,
   output wire        at_top,
   output wire        at_bottom
);

   `include "tcc_timer_defs.vh"

   reg [15:0] count_next;  // Next counter value.
   reg        down_next;   // Next counting direction.

   // Limit indications for the mode and waveform logic.
   assign at_top    = (count_reg == top_value);
   assign at_bottom = (count_reg == `TCC_BOTTOM);

   // Next-state logic; a CPU load beats every clear and count step.
   always @* begin
      count_next = count_reg;
      down_next  = down_reg;
      if (load) begin
         count_next = load_value;
      end else if (tick) begin
         if (dual_slope) begin
            // Turn round at the limits so the slope stays symmetrical.
            if (!down_reg && count_reg >= top_value) begin
               down_next  = 1'b1;
               count_next = count_reg - 16'h0001;
            end else if (down_reg && at_bottom) begin
               down_next  = 1'b0;
               count_next = count_reg + 16'h0001;
            end else if (down_reg) begin
               count_next = count_reg - 16'h0001;
            end else begin
               count_next = count_reg + 16'h0001;
            end
         end else if (count_reg >= top_value) begin
            // A value above the limit also clears, so a lowered limit cannot hang the count.
            count_next = `TCC_BOTTOM;
         end else begin
            count_next = count_reg + 16'h0001;
         end
      end
   end

   // State registers.
   always @(posedge sys_clk) begin
      if (rst) begin
         count_reg <= `TCC_RST_WORD;
         down_reg  <= 1'b0;
      end else begin
         count_reg <= count_next;
         down_reg  <= down_next;
      end
   end

endmodule // tcc_counter

`default_nettype wire

// ### test/tcc_timer_monitor.sv
`default_nettype none
`include "tcc_timer_defs.vh"

// Watches the timer's bus and counter ports.
module tcc_timer_monitor (
   // Clock and reset.
   input wire logic        sys_clk,
   input wire logic        rst,
   // Bus side.
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   // Counter side.
   input wire logic        timer_tick,
   input wire logic [2:0]  clock_source_sel,
   input wire logic        count_overflow_flag,
   input wire logic [15:0] timer_count_value,
   input wire logic        bottom_reached
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Access phase, low-byte counter write and a live tick.
   wire logic       acc   = psel && penable;
   wire logic       wr_lo = acc && pwrite && paddr == `TCC_OFS_COUNT_LO;
   wire logic       step  = timer_tick && clock_source_sel != `TCC_CS_STOPPED && !wr_lo;
   wire logic [7:0] wbyte = pwdata[7:0];
   wire logic [7:0] hbyte = timer_count_value[15:8];
   // Bus steps from which the byte-pair properties are built.
   sequence s_wr(a); acc && pwrite && paddr == a; endsequence
   sequence s_rd(a); acc && !pwrite && paddr == a; endsequence
   sequence s_setup(a); psel && !penable && !pwrite && paddr == a; endsequence
   property p_bottom; bottom_reached == (timer_count_value == `TCC_BOTTOM); endproperty
   property p_stop;
      clock_source_sel == `TCC_CS_STOPPED && !wr_lo |=> $stable(timer_count_value);
   endproperty
   property p_load; wr_lo |=> timer_count_value[7:0] == $past(wbyte); endproperty
   property p_step;
      step |=> timer_count_value == $past(timer_count_value) + 16'h0001
         || timer_count_value == $past(timer_count_value) - 16'h0001
         || timer_count_value == `TCC_BOTTOM;
   endproperty
   property p_ovf; $rose(count_overflow_flag) |-> $past(timer_tick); endproperty
   property p_rst;
      $fell(rst) |-> timer_count_value == `TCC_RST_WORD
         && clock_source_sel == `TCC_RST_CS && !count_overflow_flag;
   endproperty
   // A later high read returns the snapshot taken at the low read's setup edge.
   property p_rd16;
      s_rd(`TCC_OFS_COUNT_LO) ##2 s_setup(`TCC_OFS_COUNT_HI) ##1 s_rd(`TCC_OFS_COUNT_HI)
         |-> prdata[7:0] == $past(hbyte, 4);
   endproperty
   property p_wr16;
      s_wr(`TCC_OFS_COUNT_HI) ##3 s_wr(`TCC_OFS_COUNT_LO) |=> hbyte == $past(wbyte, 4);
   endproperty
   // The latch filled through compare B still serves a later counter load.
   property p_share;
      s_wr(`TCC_OFS_CMPB_HI) ##3 s_wr(`TCC_OFS_CMPB_LO) ##3 s_wr(`TCC_OFS_COUNT_LO)
         |=> hbyte == $past(wbyte, 7);
   endproperty
   a_bottom: assert property (p_bottom) else $error("bottom flag wrong");
   a_stop: assert property (p_stop) else $error("stopped counter moved");
   a_load: assert property (p_load) else $error("low write not loaded");
   a_step: assert property (p_step) else $error("tick step wrong");
   a_ovf: assert property (p_ovf) else $error("flag set without tick");
   a_rst: assert property (p_rst) else $error("reset state wrong");
   a_rd16: assert property (p_rd16) else $error("latched high read wrong");
   a_wr16: assert property (p_wr16) else $error("16-bit write wrong");
   a_share: assert property (p_share) else $error("shared latch lost");
endmodule // tcc_timer_monitor

bind tcc_timer tcc_timer_monitor tcc_timer_monitor_i (.sys_clk(sys_clk), .rst(rst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .timer_tick(timer_tick), .clock_source_sel(clock_source_sel),
   .count_overflow_flag(count_overflow_flag), .timer_count_value(timer_count_value),
   .bottom_reached(bottom_reached));

`default_nettype wire

// ### test/tcc_cpu_model.sv
`default_nettype none

// Bus master standing in for the processor core.
module tcc_cpu_model (
   // Clock.
   input  wire logic        sys_clk,
   // Bus requests.
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   // Bus answers.
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   timeunit 1ns;
   timeprecision 100ps;
   // Idle bus at time zero.
   initial begin
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end
   // One transfer; entered just after a rising edge, leaves one idle cycle.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'h1;
      do @(posedge sys_clk); while (pready !== 1'h1);
      r = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      // Released data does not keep its last value.
      pwdata <= ~d;
      @(posedge sys_clk);
   endtask
   // Byte pairs; only one thread issues them, so the latch is never shared midway.
   task automatic wr16(input logic [7:0] lo, input logic [15:0] v);
      logic [31:0] r;
      logic        e;
      xfer(1'h1, lo + 8'h04, {24'h0, v[15:8]}, r, e);
      xfer(1'h1, lo, {24'h0, v[7:0]}, r, e);
   endtask
   task automatic rd16(input logic [7:0] lo, output logic [15:0] v);
      logic [31:0] rl, rh;
      logic        e;
      xfer(1'h0, lo, 32'h0, rl, e);
      xfer(1'h0, lo + 8'h04, 32'h0, rh, e);
      v = {rh[7:0], rl[7:0]};
   endtask
endmodule // tcc_cpu_model

`default_nettype wire

// ### test/tcc_timer_tb.sv
`default_nettype none
`include "tcc_timer_defs.vh"

// Self-checking bench for the timer core.
module tcc_timer_tb;
   timeunit 1ns;
   timeprecision 100ps;
   // Table row: low-byte address, written word, expected read.
   typedef struct packed {
      logic [7:0]  lo;
      logic [15:0] wv;
      logic [15:0] ev;
   } tcc_row_t;
   // Capture ignores low writes in mode 0, so its row reads back zero.
   tcc_row_t rows [4] = '{'{`TCC_OFS_COUNT_LO, 16'h01FF, 16'h01FF},
      '{`TCC_OFS_CMPA_LO, 16'h1234, 16'h1234}, '{`TCC_OFS_CMPB_LO, 16'hABCD, 16'hABCD},
      '{`TCC_OFS_CAPT_LO, 16'h5A5A, 16'h0000}};
   logic        sys_clk, rst, timer_tick, psel, penable, pwrite, pready, pslverr;
   logic        ovf, top_hit, bot_hit, down;
   logic [15:0] cmpa_v, cmpb_v, capt_v;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, r;
   logic        e;
   int          err_count = 0;
   int          checks_done = 0;
   tcc_timer tcc_timer_i (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .timer_tick(timer_tick), .clock_source_sel(),
      .count_overflow_flag(ovf), .timer_count_value(), .compare_a_value(cmpa_v),
      .compare_b_value(cmpb_v), .capture_value(capt_v), .top_reached(top_hit),
      .bottom_reached(bot_hit), .count_down(down));
   tcc_cpu_model tcc_cpu_model_i (.sys_clk(sys_clk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   // Compare and count; an unknown never matches.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
         err_count++;
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ev);
      tcc_cpu_model_i.xfer(1'h0, a, 32'h0, r, e);
      chk(r, ev);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      tcc_cpu_model_i.xfer(1'h1, a, d, r, e);
   endtask
   task automatic r16(input logic [7:0] lo, input logic [15:0] ev);
      logic [15:0] v;
      tcc_cpu_model_i.rd16(lo, v);
      chk({16'h0, v}, {16'h0, ev});
   endtask
   // Single place where the run ends.
   task automatic end_of_test;
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Clock at 200 MHz.
   initial begin
      sys_clk = 1'h0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   // Watchdog well beyond the expected few hundred cycles.
   initial begin
      repeat (20000) @(posedge sys_clk);
      err_count++;
      end_of_test;
   end
   // Main sequence.
   initial begin
      rst = 1'h1;
      timer_tick = 1'h0;
      repeat (4) @(posedge sys_clk);
      rst <= 1'h0;
      @(posedge sys_clk);
      rd(`TCC_OFS_CTRL_B, 32'h0);
      rd(`TCC_OFS_FLAGS, 32'h0);
      r16(`TCC_OFS_COUNT_LO, 16'h0000);
      foreach (rows[i]) begin
         tcc_cpu_model_i.wr16(rows[i].lo, rows[i].wv);
         r16(rows[i].lo, rows[i].ev);
      end
      // Compare high read bypasses the latch holding the counter's high byte.
      rd(`TCC_OFS_COUNT_LO, 32'hFF);
      rd(`TCC_OFS_CMPA_HI, 32'h12);
      rd(`TCC_OFS_COUNT_HI, 32'h01);
      // One high write serves two low writes.
      wr(`TCC_OFS_CMPB_HI, 32'h77);
      wr(`TCC_OFS_CMPB_LO, 32'h11);
      wr(`TCC_OFS_COUNT_LO, 32'h22);
      r16(`TCC_OFS_COUNT_LO, 16'h7722);
      r16(`TCC_OFS_CMPB_LO, 16'h7711);
      chk({16'h0, cmpb_v}, 32'h00007711);
      // Ticks with no clock source leave the counter alone.
      timer_tick <= 1'h1;
      repeat (4) @(posedge sys_clk);
      r16(`TCC_OFS_COUNT_LO, 16'h7722);
      // Running counter: the load edge must not also count; one idle edge follows.
      wr(`TCC_OFS_CTRL_B, 32'h1);
      tcc_cpu_model_i.wr16(`TCC_OFS_COUNT_LO, 16'h0100);
      timer_tick <= 1'h0;
      r16(`TCC_OFS_COUNT_LO, 16'h0101);
      // Wrap from the maximum sets the overflow flag.
      tcc_cpu_model_i.wr16(`TCC_OFS_COUNT_LO, 16'hFFFF);
      timer_tick <= 1'h1;
      @(posedge sys_clk);
      timer_tick <= 1'h0;
      r16(`TCC_OFS_COUNT_LO, 16'h0000);
      chk({31'h0, bot_hit}, 32'h1);
      rd(`TCC_OFS_FLAGS, 32'h1);
      wr(`TCC_OFS_FLAGS, 32'h1);
      rd(`TCC_OFS_FLAGS, 32'h0);
      // Dual slope with limit 0x00FF turns round at the limit.
      wr(`TCC_OFS_CTRL_A, 32'h1);
      tcc_cpu_model_i.wr16(`TCC_OFS_COUNT_LO, 16'h00FF);
      chk({31'h0, top_hit}, 32'h1);
      timer_tick <= 1'h1;
      @(posedge sys_clk);
      timer_tick <= 1'h0;
      r16(`TCC_OFS_COUNT_LO, 16'h00FE);
      chk({31'h0, down}, 32'h1);
      // Unmapped address is refused.
      tcc_cpu_model_i.xfer(1'h0, 8'h2C, 32'h0, r, e);
      chk({31'h0, e}, 32'h1);
      // Mode 15: compare A is the limit and waits in its buffer until the limit tick.
      chk({16'h0, cmpa_v}, 32'h00001234);
      wr(`TCC_OFS_CTRL_A, 32'h3);
      wr(`TCC_OFS_CTRL_B, 32'h19);
      tcc_cpu_model_i.wr16(`TCC_OFS_CMPA_LO, 16'h0010);
      chk({16'h0, cmpa_v}, 32'h00001234);
      tcc_cpu_model_i.wr16(`TCC_OFS_COUNT_LO, 16'h1234);
      timer_tick <= 1'h1;
      @(posedge sys_clk);
      timer_tick <= 1'h0;
      @(posedge sys_clk);
      chk({16'h0, cmpa_v}, 32'h00000010);
      r16(`TCC_OFS_COUNT_LO, 16'h0000);
      rd(`TCC_OFS_FLAGS, 32'h1);
      // Mode 12: the capture register becomes writable and sets the limit.
      wr(`TCC_OFS_CTRL_A, 32'h0);
      wr(`TCC_OFS_CTRL_B, 32'h18);
      tcc_cpu_model_i.wr16(`TCC_OFS_CAPT_LO, 16'h0300);
      chk({16'h0, capt_v}, 32'h00000300);
      r16(`TCC_OFS_CAPT_LO, 16'h0300);
      tcc_cpu_model_i.wr16(`TCC_OFS_COUNT_LO, 16'h0300);
      chk({31'h0, top_hit}, 32'h1);
      // Reset in mid-run with a dirty latch, count, mode and flag.
      rst <= 1'h1;
      repeat (4) @(posedge sys_clk);
      rst <= 1'h0;
      @(posedge sys_clk);
      rd(`TCC_OFS_COUNT_HI, 32'h0);
      r16(`TCC_OFS_COUNT_LO, 16'h0000);
      rd(`TCC_OFS_CTRL_B, 32'h0);
      rd(`TCC_OFS_FLAGS, 32'h0);
      end_of_test;
   end
endmodule // tcc_timer_tb

`default_nettype wire
